// ===== bench/bfs_brk_model.sv
module bfs_brk_model (
	// Clock and reset
	input  wire logic                                  ref_clk,
	input  wire logic                                  rst_n,
	// Scheme and bench commands
	input  wire logic [bfs_pkg::N_POLE-1:0]            retrip,
	input  wire logic                                  stuck,
	input  wire logic                                  aux_lie,
	input  wire logic                                  close_cmd,
	input  wire logic [bfs_pkg::MAG_W-1:0]             fault_level,
	// Breaker state
	output logic      [bfs_pkg::N_POLE-1:0]            fast_aux,
	output logic      [bfs_pkg::N_POLE-1:0]            normal_aux,
	output logic      [bfs_pkg::N_POLE-1:0][bfs_pkg::MAG_W-1:0] phase_mag,
	output logic      [bfs_pkg::MAG_W-1:0]             neutral_mag
);
	timeunit 1ns;
	timeprecision 1ps;
	import bfs_pkg::*;
	logic       closed_reg;
	logic [3:0] open_cnt_reg;
	// Healthy breaker opens 8 cycles after retrip, inside the shortest early delay
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			closed_reg   <= 1'b1;
			open_cnt_reg <= 4'h0;
		end else if (close_cmd) begin
			closed_reg   <= 1'b1;
			open_cnt_reg <= 4'h0;
		end else if (|retrip && !stuck) begin
			open_cnt_reg <= open_cnt_reg + 4'h1;
			if (open_cnt_reg == 4'h7) begin
				closed_reg <= 1'b0;
			end
		end
	end
	// Lying aux reports open while poles still carry current
	assign fast_aux    = {N_POLE{closed_reg && !aux_lie}};
	assign normal_aux  = {N_POLE{closed_reg && !aux_lie}};
	assign phase_mag   = {N_POLE{closed_reg ? fault_level : 16'h0000}};
	assign neutral_mag = closed_reg ? fault_level : 16'h0000;
endmodule

// ===== bench/breaker_failure_scheme_tb_top.sv
module breaker_failure_scheme_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bfs_pkg::*;
	logic                  ref_clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic [1:0]            fn_en = 2'h1, scheme = 2'h0, src = 2'h0, sup_en = 2'h0, latch_en = 2'h0;
	logic [1:0]            e_en = 2'h0, m_en = 2'h0, s_en = 2'h0, init3 = 2'h0, blk = 2'h0, oos = 2'h0;
	logic [1:0]            t_rst = 2'h0;
	logic [1:0][15:0]      e_dly = {2{16'h0002}}, m_dly = {2{16'h0004}}, s_dly = {2{16'h0006}};
	logic [1:0][15:0]      lo_dly = {2{16'h0002}}, hold_dly = {2{16'h0003}};
	logic [1:0][14:0]      thr_sup = {2{15'h03E8}}, thr_lo = {2{15'h01F4}}, thr_nsup = {2{15'h03E8}};
	logic [1:0][2:0]       pole_init = 6'h00;
	logic                  stuck = 1'b0, lie = 1'b0, close_cmd = 1'b0;
	logic [15:0]           level = 16'h07D0;
	wire  [1:0][2:0]       f_aux, n_aux;
	wire  [1:0][2:0][15:0] ph_mag;
	wire  [1:0][15:0]      n_mag;
	logic [1:0][2:0]       retrip, ph_led;
	logic [1:0]            initd, e_op, m_op, s_op, zone, tgt, led;
	int                    n_fail = 0, n_tests = 0, cyc_cnt = 0;
	assign f_aux[1] = 3'h0;
	assign n_aux[1] = 3'h0;
	assign ph_mag[1] = '0;
	assign n_mag[1] = 16'h0000;

	bfs_top #(.MS_TICK_CYCLES(10)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .bf_function_enable(fn_en),
		.pole_scheme_select(scheme), .measurement_source_select(src), .current_supervised_initiate_en(sup_en),
		.initiate_latch_en(latch_en), .early_path_en(e_en), .main_path_en(m_en), .slow_path_en(s_en),
		.early_path_delay(e_dly), .main_path_delay(m_dly), .slow_path_delay(s_dly), .loset_delay(lo_dly),
		.trip_hold_delay(hold_dly), .phase_supervision_threshold(thr_sup), .neutral_supervision_threshold(thr_nsup),
		.phase_high_threshold(thr_sup), .neutral_high_threshold(thr_sup), .phase_low_threshold(thr_lo),
		.neutral_low_threshold(thr_lo), .three_pole_initiate_in(init3), .pole_initiate_in(pole_init),
		.scheme_block_in(blk), .out_of_service_in(oos), .fast_aux_contact_in(f_aux),
		.normal_aux_contact_in(n_aux), .target_reset_in(t_rst), .phase_mag(ph_mag), .neutral_mag(n_mag),
		.retrip_out(retrip), .initiated_out(initd), .early_path_op(e_op), .main_path_op(m_op),
		.slow_path_op(s_op), .zone_trip_out(zone), .failed_target(tgt), .trip_led(led), .phase_led(ph_led));

	bfs_brk_model brk (.ref_clk(ref_clk), .rst_n(rst_n), .retrip(retrip[0]), .stuck(stuck), .aux_lie(lie),
		.close_cmd(close_cmd), .fault_level(level), .fast_aux(f_aux[0]), .normal_aux(n_aux[0]),
		.phase_mag(ph_mag[0]), .neutral_mag(n_mag[0]));

	always #10 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			n_fail++;
			test_done();
		end
	end

	task automatic test_done();
		if (n_fail == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic w(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic trip(input logic v);
		@(posedge ref_clk);
		init3[0] <= v;
	endtask

	// Paths, breaker behaviour
	task automatic cfg(input logic e, input logic m, input logic s, input logic st, input logic l);
		@(posedge ref_clk);
		e_en[0] <= e;
		m_en[0] <= m;
		s_en[0] <= s;
		stuck <= st;
		lie <= l;
	endtask

	// Drop initiate, reclose breaker, clear targets
	task automatic settle();
		@(posedge ref_clk);
		init3 <= 2'h0;
		close_cmd <= 1'b1;
		t_rst <= 2'h1;
		w(60);
		@(posedge ref_clk);
		close_cmd <= 1'b0;
		t_rst <= 2'h0;
		w(3);
	endtask

	task automatic t_retrip();
		cfg(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
		trip(1'b1);
		w(3);
		chk({retrip[0], initd[0]}, 16'h000F);
		w(80);
		chk({zone[0], tgt[0]}, 16'h0000);
		chk({retrip[1], initd[1], zone[1]}, 16'h0000);
		settle();
	endtask

	task automatic t_refuse();
		@(posedge ref_clk);
		sup_en[0] <= 1'b1;
		level <= 16'h0190;
		trip(1'b1);
		w(8);
		chk({retrip[0], initd[0]}, 16'h0000);
		@(posedge ref_clk);
		level <= 16'h07D0;
		w(5);
		chk(initd[0], 16'h0001);
		@(posedge ref_clk);
		sup_en[0] <= 1'b0;
		settle();
	endtask

	task automatic t_paths(input logic l);
		cfg(1'b1, 1'b1, 1'b0, 1'b1, l);
		trip(1'b1);
		w(30);
		chk({e_op[0], m_op[0], zone[0]}, {13'h0000, !l, 1'b0, !l});
		w(20);
		chk({m_op[0], zone[0], tgt[0], led[0]}, 16'h000F);
		chk(ph_led[0], 16'h0000);
		trip(1'b0);
		w(15);
		chk(zone[0], 16'h0001);
		w(30);
		chk({zone[0], tgt[0]}, 16'h0001);
		settle();
	endtask

	task automatic t_slow();
		cfg(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
		@(posedge ref_clk);
		level <= 16'h0000;
		oos[0] <= 1'b1;
		trip(1'b1);
		w(90);
		chk({s_op[0], zone[0]}, 16'h0000);
		@(posedge ref_clk);
		oos[0] <= 1'b0;
		w(80);
		chk({s_op[0], zone[0]}, 16'h0003);
		@(posedge ref_clk);
		level <= 16'h07D0;
		settle();
	endtask

	// Block input, then cleared function enable, during a failure
	task automatic t_kill(input int k);
		cfg(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		trip(1'b1);
		w(55);
		chk({zone[0], tgt[0]}, 16'h0003);
		@(posedge ref_clk);
		if (k == 0) blk[0] <= 1'b1;
		else fn_en[0] <= 1'b0;
		w(5);
		chk({retrip[0], initd[0], m_op[0], zone[0], tgt[0], led[0]}, 16'h0000);
		trip(1'b0);
		@(posedge ref_clk);
		blk[0] <= 1'b0;
		fn_en[0] <= 1'b1;
		settle();
	endtask

	// Seal-in keeps initiation while current stays above supervision
	task automatic t_seal();
		cfg(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		@(posedge ref_clk);
		latch_en[0] <= 1'b1;
		trip(1'b1);
		w(5);
		trip(1'b0);
		w(5);
		chk(initd[0], 16'h0001);
		@(posedge ref_clk);
		level <= 16'h0190;
		w(3);
		chk({retrip[0], initd[0]}, 16'h0000);
		@(posedge ref_clk);
		latch_en[0] <= 1'b0;
		level <= 16'h07D0;
		settle();
	endtask

	// Current between lo-set and hi-set waits for the lo-set delay
	task automatic t_loset();
		cfg(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		@(posedge ref_clk);
		level <= 16'h02EE;
		trip(1'b1);
		w(38);
		chk({m_op[0], zone[0]}, 16'h0000);
		w(28);
		chk({m_op[0], zone[0]}, 16'h0003);
		trip(1'b0);
		@(posedge ref_clk);
		level <= 16'h07D0;
		settle();
	endtask

	// Single-pole scheme, pole B alone, neutral supervision ignored
	task automatic t_single();
		cfg(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		@(posedge ref_clk);
		scheme[0] <= 1'b1;
		sup_en[0] <= 1'b1;
		thr_nsup[0] <= 15'h00C8;
		level <= 16'h0190;
		pole_init[0] <= 3'h2;
		w(6);
		chk(retrip[0], 16'h0000);
		@(posedge ref_clk);
		level <= 16'h07D0;
		w(4);
		chk({retrip[0], initd[0]}, 16'h0005);
		w(50);
		chk({ph_led[0], zone[0], tgt[0]}, 16'h000B);
		@(posedge ref_clk);
		scheme[0] <= 1'b0;
		sup_en[0] <= 1'b0;
		thr_nsup[0] <= 15'h03E8;
		pole_init[0] <= 3'h0;
		settle();
	endtask

	initial begin
		w(2);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		w(2);
		chk({retrip, zone, tgt, initd}, 16'h0000);
		t_retrip();
		t_refuse();
		t_paths(1'b0);
		t_paths(1'b1);
		t_slow();
		t_kill(0);
		t_kill(1);
		t_seal();
		t_loset();
		t_single();
		test_done();
	end
endmodule

// ===== hw/bfs_timer.sv
module bfs_timer (
	// Clock and reset
	input  wire logic   ref_clk,
	input  wire logic   rst_n,
	// Timer request
	bfs_timer_if.timer  tp
);
	import bfs_pkg::*;

	bfs_tmr_s st_reg;
	bfs_tmr_s st_next;

	// Counts ms ticks, saturating at the delay
	always_comb begin
		st_next = st_reg;
		if (!tp.run) begin
			st_next.count = '0;
		end else if (tp.tick && (st_reg.count < tp.delay)) begin
			st_next.count = DLY_W'(st_reg.count + 1'b1);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tp.done = tp.run && (st_reg.count >= tp.delay);

	AST_TIMER_RESTART: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!tp.run |=> (st_reg.count == '0))
		else $error("timer did not restart after run dropped");
	AST_TIMER_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(tp.run && tp.tick && !tp.done) ##1 tp.run |-> (st_reg.count == $past(st_reg.count) + 1'b1))
		else $error("timer missed a tick");
endmodule

// ===== hw/bfs_top.sv
module bfs_top #(
	parameter int MS_TICK_CYCLES = bfs_pkg::MS_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                                                      ref_clk,
	input  wire logic                                                      rst_n,
	// Scheme settings, one entry per instance
	input  wire logic [bfs_pkg::N_INST-1:0]                                bf_function_enable,
	input  wire logic [bfs_pkg::N_INST-1:0]                                pole_scheme_select,
	input  wire logic [bfs_pkg::N_INST-1:0]                                measurement_source_select,
	input  wire logic [bfs_pkg::N_INST-1:0]                                current_supervised_initiate_en,
	input  wire logic [bfs_pkg::N_INST-1:0]                                initiate_latch_en,
	input  wire logic [bfs_pkg::N_INST-1:0]                                early_path_en,
	input  wire logic [bfs_pkg::N_INST-1:0]                                main_path_en,
	input  wire logic [bfs_pkg::N_INST-1:0]                                slow_path_en,
	// Delays in ms
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::DLY_W-1:0]            early_path_delay,
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::DLY_W-1:0]            main_path_delay,
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::DLY_W-1:0]            slow_path_delay,
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::DLY_W-1:0]            loset_delay,
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::DLY_W-1:0]            trip_hold_delay,
	// Thresholds in 0.001 pu
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::THR_W-1:0]            phase_supervision_threshold,
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::THR_W-1:0]            neutral_supervision_threshold,
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::THR_W-1:0]            phase_high_threshold,
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::THR_W-1:0]            neutral_high_threshold,
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::THR_W-1:0]            phase_low_threshold,
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::THR_W-1:0]            neutral_low_threshold,
	// Trip, block and breaker contact inputs
	input  wire logic [bfs_pkg::N_INST-1:0]                                three_pole_initiate_in,
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::N_POLE-1:0]           pole_initiate_in,
	input  wire logic [bfs_pkg::N_INST-1:0]                                scheme_block_in,
	input  wire logic [bfs_pkg::N_INST-1:0]                                out_of_service_in,
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::N_POLE-1:0]           fast_aux_contact_in,
	input  wire logic [bfs_pkg::N_INST-1:0][bfs_pkg::N_POLE-1:0]           normal_aux_contact_in,
	input  wire logic [bfs_pkg::N_INST-1:0]                                target_reset_in,
	// Current magnitudes per source in 0.001 pu
	input  wire logic [1:0][bfs_pkg::N_POLE-1:0][bfs_pkg::MAG_W-1:0]       phase_mag,
	input  wire logic [1:0][bfs_pkg::MAG_W-1:0]                            neutral_mag,
	// Scheme outputs
	output logic      [bfs_pkg::N_INST-1:0][bfs_pkg::N_POLE-1:0]           retrip_out,
	output logic      [bfs_pkg::N_INST-1:0]                                initiated_out,
	output logic      [bfs_pkg::N_INST-1:0]                                early_path_op,
	output logic      [bfs_pkg::N_INST-1:0]                                main_path_op,
	output logic      [bfs_pkg::N_INST-1:0]                                slow_path_op,
	output logic      [bfs_pkg::N_INST-1:0]                                zone_trip_out,
	// Indications
	output logic      [bfs_pkg::N_INST-1:0]                                failed_target,
	output logic      [bfs_pkg::N_INST-1:0]                                trip_led,
	output logic      [bfs_pkg::N_INST-1:0][bfs_pkg::N_POLE-1:0]           phase_led
);
	import bfs_pkg::*;

	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_TICK_CYCLES - 1);

	bfs_state_s st_reg;
	bfs_state_s st_next;

	logic [N_INST-1:0][SYNC_W-1:0]             sync_in;
	logic [N_INST-1:0][N_TMR-1:0][DLY_W-1:0]   dly_w;
	logic [N_INST-1:0][N_POLE-1:0]             active_w;
	logic [N_INST-1:0][N_POLE-1:0]             cur_sup_w;
	logic [N_INST-1:0][N_POLE-1:0]             f_early_w;
	logic [N_INST-1:0][N_POLE-1:0]             f_main_w;
	logic [N_INST-1:0][N_POLE-1:0]             f_slow_w;
	logic [N_INST-1:0][N_POLE-1:0]             fail_w;
	logic [N_INST-1:0][N_POLE-1:0][N_TMR-1:0]  run_w;
	logic [N_INST-1:0][N_POLE-1:0][N_TMR-1:0]  done_w;
	logic [N_INST-1:0]                         en_w;

	// Threshold held inside its settable span
	function automatic logic [THR_W-1:0] thr_clamp(input logic [THR_W-1:0] thr);
		logic [THR_W-1:0] r;
		r = thr;
		if (thr < THR_MIN) begin
			r = THR_MIN;
		end else if (thr > THR_MAX) begin
			r = THR_MAX;
		end
		return r;
	endfunction

	// Level detector used by every current check
	function automatic logic above(input logic [MAG_W-1:0] mag, input logic [THR_W-1:0] thr);
		return mag >= {1'b0, thr_clamp(thr)};
	endfunction

	genvar gi, gp, gt;
	generate
		for (gi = 0; gi < N_INST; gi++) begin : g_inst
			assign sync_in[gi] = {target_reset_in[gi], normal_aux_contact_in[gi], fast_aux_contact_in[gi],
				out_of_service_in[gi], scheme_block_in[gi], pole_initiate_in[gi], three_pole_initiate_in[gi]};
			assign dly_w[gi] = {loset_delay[gi], slow_path_delay[gi], main_path_delay[gi], early_path_delay[gi]};
			// Running only while enabled and not blocked
			assign en_w[gi] = bf_function_enable[gi] && !st_reg.sy2[gi][SY_BLOCK];

			for (gp = 0; gp < N_POLE; gp++) begin : g_pole
				logic            single;
				logic            init_p;
				logic            aux_f;
				logic            aux_n;
				logic            oos;
				logic [MAG_W-1:0] ph;
				logic [MAG_W-1:0] nm;
				logic            cur_hi;
				logic            cur_lo;
				logic            det;

				assign single = (pole_scheme_select[gi] == BFS_SINGLE_POLE);
				// Per-pole initiate only in the single-pole scheme
				assign init_p = st_reg.sy2[gi][SY_INIT3] || (single && st_reg.sy2[gi][SY_INITP+gp]);
				assign aux_f = single ? st_reg.sy2[gi][SY_AUXF+gp] : st_reg.sy2[gi][SY_AUXF];
				assign aux_n = single ? st_reg.sy2[gi][SY_AUXN+gp] : st_reg.sy2[gi][SY_AUXN];
				assign oos = st_reg.sy2[gi][SY_OOS];
				assign ph = phase_mag[measurement_source_select[gi]][gp];
				assign nm = neutral_mag[measurement_source_select[gi]];

				// Neutral checks only count in the three-pole scheme
				assign cur_sup_w[gi][gp] = above(ph, phase_supervision_threshold[gi])
					|| (!single && above(nm, neutral_supervision_threshold[gi]));
				assign cur_hi = above(ph, phase_high_threshold[gi])
					|| (!single && above(nm, neutral_high_threshold[gi]));
				assign cur_lo = above(ph, phase_low_threshold[gi])
					|| (!single && above(nm, neutral_low_threshold[gi]));

				// Initiation, optionally current supervised, plus seal-in latch
				assign active_w[gi][gp] = en_w[gi] && ((init_p && (!current_supervised_initiate_en[gi]
					|| cur_sup_w[gi][gp])) || st_reg.inst[gi].latch[gp]);

				assign run_w[gi][gp][T_EARLY] = active_w[gi][gp] && early_path_en[gi];
				assign run_w[gi][gp][T_MAIN]  = active_w[gi][gp] && main_path_en[gi];
				assign run_w[gi][gp][T_SLOW]  = active_w[gi][gp] && slow_path_en[gi] && !oos;
				// Lo-set delay starts when early or main delay runs out
				assign run_w[gi][gp][T_LOSET] = done_w[gi][gp][T_EARLY] || done_w[gi][gp][T_MAIN];

				// Detectors looked at only after the path delay
				assign det = (run_w[gi][gp][T_LOSET] && cur_hi) || (done_w[gi][gp][T_LOSET] && cur_lo);
				assign f_early_w[gi][gp] = done_w[gi][gp][T_EARLY] && aux_f && det;
				assign f_main_w[gi][gp]  = done_w[gi][gp][T_MAIN] && det;
				assign f_slow_w[gi][gp]  = done_w[gi][gp][T_SLOW] && aux_n && !oos;
				assign fail_w[gi][gp] = f_early_w[gi][gp] || f_main_w[gi][gp] || f_slow_w[gi][gp];

				for (gt = 0; gt < N_TMR; gt++) begin : g_tmr
					bfs_timer_if u_if ();
					assign u_if.tick  = st_reg.tick;
					assign u_if.run   = run_w[gi][gp][gt];
					assign u_if.delay = dly_w[gi][gt];
					assign done_w[gi][gp][gt] = u_if.done;
					bfs_timer u_tmr (
						.ref_clk (ref_clk),
						.rst_n   (rst_n),
						.tp      (u_if.timer)
					);
				end
			end
		end
	endgenerate

	always_comb begin
		st_next = st_reg;
		st_next.sy1 = sync_in;
		st_next.sy2 = st_reg.sy1;
		// Free-running 1 ms tick
		if (st_reg.tick_cnt >= TICK_LAST) begin
			st_next.tick_cnt = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.tick_cnt = TICK_W'(st_reg.tick_cnt + 1'b1);
			st_next.tick = 1'b0;
		end
		for (int i = 0; i < N_INST; i++) begin
			if (!en_w[i]) begin
				st_next.inst[i] = '0;
			end else begin
				// Seal-in holds only while supervision current stays up
				st_next.inst[i].latch = {N_POLE{initiate_latch_en[i]}} & active_w[i] & cur_sup_w[i];
				st_next.inst[i].retrip = active_w[i];
				st_next.inst[i].initiated = |active_w[i];
				st_next.inst[i].early_op = |f_early_w[i];
				st_next.inst[i].main_op = |f_main_w[i];
				st_next.inst[i].slow_op = |f_slow_w[i];
				// Zone trip hold countdown
				if (|fail_w[i]) begin
					st_next.inst[i].hold_cnt = trip_hold_delay[i];
				end else if (st_reg.tick && (st_reg.inst[i].hold_cnt != '0)) begin
					st_next.inst[i].hold_cnt = DLY_W'(st_reg.inst[i].hold_cnt - 1'b1);
				end
				st_next.inst[i].zone_trip = (|fail_w[i]) || (st_next.inst[i].hold_cnt != '0);
				// Sticky indications, a new failure beats a reset
				st_next.inst[i].target = (|fail_w[i])
					|| (st_reg.inst[i].target && !st_reg.sy2[i][SY_TRST]);
				st_next.inst[i].trip_led = (|fail_w[i])
					|| (st_reg.inst[i].trip_led && !st_reg.sy2[i][SY_TRST]);
				st_next.inst[i].phase_led = ((pole_scheme_select[i] == BFS_SINGLE_POLE) ? fail_w[i] : '0)
					| (st_reg.inst[i].phase_led & {N_POLE{!st_reg.sy2[i][SY_TRST]}});
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	always_comb begin
		for (int i = 0; i < N_INST; i++) begin
			retrip_out[i]    = st_reg.inst[i].retrip;
			initiated_out[i] = st_reg.inst[i].initiated;
			early_path_op[i] = st_reg.inst[i].early_op;
			main_path_op[i]  = st_reg.inst[i].main_op;
			slow_path_op[i]  = st_reg.inst[i].slow_op;
			zone_trip_out[i] = st_reg.inst[i].zone_trip;
			failed_target[i] = st_reg.inst[i].target;
			trip_led[i]      = st_reg.inst[i].trip_led;
			phase_led[i]     = st_reg.inst[i].phase_led;
		end
	end

	generate
		for (gi = 0; gi < N_INST; gi++) begin : g_chk
			sequence s_failing;
				|fail_w[gi];
			endsequence
			sequence s_failed_shown;
				zone_trip_out[gi] && failed_target[gi] && trip_led[gi];
			endsequence
			sequence s_inhibit;
				!en_w[gi];
			endsequence

			AST_RETRIP_NOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
				active_w[gi] != '0 |=> (retrip_out[gi] == $past(active_w[gi])))
				else $error("retrip did not follow initiation");
			AST_BLOCK_CLEARS: assert property (@(posedge ref_clk) disable iff (!rst_n)
				s_inhibit |=> (retrip_out[gi] == '0) && !zone_trip_out[gi] && !initiated_out[gi])
				else $error("block or disable left scheme active");
			AST_DISABLE_RESETS: assert property (@(posedge ref_clk) disable iff (!rst_n)
				!bf_function_enable[gi] ##1 !bf_function_enable[gi] |-> !failed_target[gi] && !trip_led[gi]
				&& (phase_led[gi] == '0) && !early_path_op[gi] && !main_path_op[gi] && !slow_path_op[gi])
				else $error("disabled instance shows activity");
			AST_FAIL_TRIPS: assert property (@(posedge ref_clk) disable iff (!rst_n)
				s_failing |=> s_failed_shown)
				else $error("failure did not raise zone trip and target");
			AST_EARLY_CAUSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
				early_path_op[gi] |-> $past(f_early_w[gi] != '0) && $past(early_path_en[gi]))
				else $error("early path operated without its conditions");
			AST_MAIN_CAUSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
				main_path_op[gi] |-> $past(f_main_w[gi] != '0) && $past(main_path_en[gi]))
				else $error("main path operated without detected current");
			AST_SLOW_OOS: assert property (@(posedge ref_clk) disable iff (!rst_n)
				st_reg.sy2[gi][SY_OOS] |=> !slow_path_op[gi])
				else $error("slow path operated while out of service");
			AST_ZONE_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
				$fell(zone_trip_out[gi]) |-> $past(st_reg.inst[gi].hold_cnt) <= 16'h0001 && en_w[gi]
				|| !$past(en_w[gi]) || !en_w[gi])
				else $error("zone trip dropped before hold expired");
			AST_SINGLE_NO_NEUTRAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
				(pole_scheme_select[gi] == BFS_SINGLE_POLE) && (phase_mag[measurement_source_select[gi]][0]
				< {1'b0, thr_clamp(phase_supervision_threshold[gi])}) |-> !cur_sup_w[gi][0])
				else $error("neutral supervision acted in single-pole scheme");
		end
	endgenerate
endmodule

// ===== inc/bfs_pkg.sv
package bfs_pkg;
	localparam int CLK_PERIOD_NS  = 20;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int MS_TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int N_INST         = 2;
	localparam int N_POLE         = 3;
	localparam int N_TMR          = 4;
	localparam int THR_W          = 15;
	localparam int MAG_W          = 16;
	localparam int DLY_W          = 16;
	localparam int TICK_W         = 16;
	localparam logic [THR_W-1:0] THR_MIN = 15'h0001;
	localparam logic [THR_W-1:0] THR_MAX = 15'h7530;
	localparam int T_EARLY        = 0;
	localparam int T_MAIN         = 1;
	localparam int T_SLOW         = 2;
	localparam int T_LOSET        = 3;
	localparam int SYNC_W         = 13;
	localparam int SY_INIT3       = 0;
	localparam int SY_INITP       = 1;
	localparam int SY_BLOCK       = 4;
	localparam int SY_OOS         = 5;
	localparam int SY_AUXF        = 6;
	localparam int SY_AUXN        = 9;
	localparam int SY_TRST        = 12;

	typedef enum logic {
		BFS_THREE_POLE  = 1'b0,
		BFS_SINGLE_POLE = 1'b1
	} bfs_scheme_e;

	typedef struct packed {
		logic [N_POLE-1:0] latch;
		logic [N_POLE-1:0] retrip;
		logic [DLY_W-1:0]  hold_cnt;
		logic              initiated;
		logic              early_op;
		logic              main_op;
		logic              slow_op;
		logic              zone_trip;
		logic              target;
		logic              trip_led;
		logic [N_POLE-1:0] phase_led;
	} bfs_inst_s;

	typedef struct packed {
		logic [N_INST-1:0][SYNC_W-1:0] sy1;
		logic [N_INST-1:0][SYNC_W-1:0] sy2;
		logic [TICK_W-1:0]             tick_cnt;
		logic                          tick;
		bfs_inst_s [N_INST-1:0]        inst;
	} bfs_state_s;

	typedef struct packed {
		logic [DLY_W-1:0] count;
	} bfs_tmr_s;
endpackage

// ===== inc/bfs_timer_if.sv
interface bfs_timer_if;
	import bfs_pkg::*;
	logic             tick;
	logic             run;
	logic [DLY_W-1:0] delay;
	logic             done;
	modport timer (input tick, input run, input delay, output done);
	modport user (output tick, output run, output delay, input done);
endinterface
